// ---- core/sseb_bank.sv ----
// Status reporting register bank: condition, event and enable mask registers.
//
// Operation
// - Condition read returns the 16-bit live value and changes nothing.
// - Operation event read returns its value, then clears it.
// - Questionable event read returns its 16-bit value, then clears it.
// - Instrument error event read returns its 8-bit value, then clears it.
// - Measurement event read returns its 8-bit value, then clears it.
// - Operation enable mask is a 16-bit writable, readable register.
// - Out-of-range mask write stores the limit and flags an execution error.
// - Operation mask ignores ones in bits 0-3 and 6-15, no error.
// - Questionable enable mask is a 16-bit writable, readable register.
// - Questionable mask ignores bits 2-3, 5-8, 10, 13, 15, no error.
// - Instrument error mask is 8-bit; bits 0, 2, 4 ignored.
// - Measurement mask is 8-bit; bits 0, 2, 4 ignored, no error.
`timescale 1ns/1ps
`include "sseb_defines.svh"

module sseb_bank (
   // Clock and reset
   input  wire logic                ref_clk,
   input  wire logic                rst_n,
   // Command interpreter request and answer
   input  wire sseb_pkg::sseb_cmd_t cmd,
   output sseb_pkg::sseb_rsp_t      rsp,
   // Status sources
   input  wire logic [15:0]         operation_condition,
   input  wire logic [15:0]         operation_set,
   input  wire logic [15:0]         questionable_set,
   input  wire logic [7:0]          instrument_error_set,
   input  wire logic [7:0]          measurement_set,
   // Summaries
   output logic                     operation_summary,
   output logic                     questionable_summary,
   output logic                     instrument_error_summary,
   output logic                     measurement_summary
);

   ////////////////////////////////////////////////////////////////////////////
   // Decode

   logic        is_read;
   logic        is_write;
   logic        rd_oper_evt;
   logic        rd_ques_evt;
   logic        rd_inst_evt;
   logic        rd_meas_evt;
   logic        wr_oper_mask;
   logic        wr_ques_mask;
   logic        wr_inst_mask;
   logic        wr_meas_mask;

   assign is_read      = cmd.valid && !cmd.write;
   assign is_write     = cmd.valid && cmd.write;
   assign rd_oper_evt  = is_read && (cmd.sel == {1'b0, `SSEB_SEL_OPER_EVT});
   assign rd_ques_evt  = is_read && (cmd.sel == {1'b0, `SSEB_SEL_QUES_EVT});
   assign rd_inst_evt  = is_read && (cmd.sel == {1'b0, `SSEB_SEL_INST_EVT});
   assign rd_meas_evt  = is_read && (cmd.sel == {1'b0, `SSEB_SEL_MEAS_EVT});
   assign wr_oper_mask = is_write && (cmd.sel == {1'b0, `SSEB_SEL_OPER_MASK});
   assign wr_ques_mask = is_write && (cmd.sel == {1'b0, `SSEB_SEL_QUES_MASK});
   assign wr_inst_mask = is_write && (cmd.sel == {1'b0, `SSEB_SEL_INST_MASK});
   assign wr_meas_mask = is_write && (cmd.sel == `SSEB_SEL_MEAS_MASK);

   ////////////////////////////////////////////////////////////////////////////
   // Masks

   logic [15:0] operation_event_mask;
   logic [15:0] questionable_event_mask;
   logic [7:0]  instrument_error_mask;
   logic [7:0]  measurement_event_mask;
   logic        err_oper;
   logic        err_ques;
   logic        err_inst;
   logic        err_meas;

   sseb_mask_reg #(.WIDTH(16), .USED(`SSEB_OPER_USED)) u_oper_mask (
      .ref_clk     (ref_clk),
      .rst_n       (rst_n),
      .write       (wr_oper_mask),
      .wr_value    (cmd.value),
      .mask        (operation_event_mask),
      .range_error (err_oper)
   );

   sseb_mask_reg #(.WIDTH(16), .USED(`SSEB_QUES_USED)) u_ques_mask (
      .ref_clk     (ref_clk),
      .rst_n       (rst_n),
      .write       (wr_ques_mask),
      .wr_value    (cmd.value),
      .mask        (questionable_event_mask),
      .range_error (err_ques)
   );

   sseb_mask_reg #(.WIDTH(8), .USED({8'h00, `SSEB_INST_USED})) u_inst_mask (
      .ref_clk     (ref_clk),
      .rst_n       (rst_n),
      .write       (wr_inst_mask),
      .wr_value    (cmd.value),
      .mask        (instrument_error_mask),
      .range_error (err_inst)
   );

   sseb_mask_reg #(.WIDTH(8), .USED({8'h00, `SSEB_MEAS_USED})) u_meas_mask (
      .ref_clk     (ref_clk),
      .rst_n       (rst_n),
      .write       (wr_meas_mask),
      .wr_value    (cmd.value),
      .mask        (measurement_event_mask),
      .range_error (err_meas)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Event registers

   logic [15:0] operation_event;
   logic [15:0] questionable_event;
   logic [7:0]  instrument_error_event;
   logic [7:0]  measurement_event;

   sseb_event_reg #(.WIDTH(16)) u_oper_evt (
      .ref_clk    (ref_clk),
      .rst_n      (rst_n),
      .event_in   (operation_set),
      .read_clear (rd_oper_evt),
      .mask       (operation_event_mask),
      .value      (operation_event),
      .summary    (operation_summary)
   );

   sseb_event_reg #(.WIDTH(16)) u_ques_evt (
      .ref_clk    (ref_clk),
      .rst_n      (rst_n),
      .event_in   (questionable_set),
      .read_clear (rd_ques_evt),
      .mask       (questionable_event_mask),
      .value      (questionable_event),
      .summary    (questionable_summary)
   );

   sseb_event_reg #(.WIDTH(8)) u_inst_evt (
      .ref_clk    (ref_clk),
      .rst_n      (rst_n),
      .event_in   (instrument_error_set),
      .read_clear (rd_inst_evt),
      .mask       (instrument_error_mask),
      .value      (instrument_error_event),
      .summary    (instrument_error_summary)
   );

   sseb_event_reg #(.WIDTH(8)) u_meas_evt (
      .ref_clk    (ref_clk),
      .rst_n      (rst_n),
      .event_in   (measurement_set),
      .read_clear (rd_meas_evt),
      .mask       (measurement_event_mask),
      .value      (measurement_event),
      .summary    (measurement_summary)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Answer

   sseb_pkg::sseb_rsp_t next_rsp;
   logic [15:0]         read_mux;

   // The read value is the pre-clear contents, sampled in the same cycle as the clear.
   always_comb begin
      read_mux = 16'h0000;
      unique case (cmd.sel)
         {1'b0, `SSEB_SEL_OPER_COND}: read_mux = operation_condition;
         {1'b0, `SSEB_SEL_OPER_EVT}:  read_mux = operation_event;
         {1'b0, `SSEB_SEL_OPER_MASK}: read_mux = operation_event_mask;
         {1'b0, `SSEB_SEL_QUES_EVT}:  read_mux = questionable_event;
         {1'b0, `SSEB_SEL_QUES_MASK}: read_mux = questionable_event_mask;
         {1'b0, `SSEB_SEL_INST_EVT}:  read_mux = {8'h00, instrument_error_event};
         {1'b0, `SSEB_SEL_INST_MASK}: read_mux = {8'h00, instrument_error_mask};
         {1'b0, `SSEB_SEL_MEAS_EVT}:  read_mux = {8'h00, measurement_event};
         `SSEB_SEL_MEAS_MASK:         read_mux = {8'h00, measurement_event_mask};
         default:                     read_mux = 16'h0000;
      endcase
      next_rsp.valid      = cmd.valid;
      next_rsp.data       = is_read ? read_mux : 16'h0000;
      next_rsp.exec_error = err_oper | err_ques | err_inst | err_meas;
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         rsp <= '0;
      end else begin
         rsp <= next_rsp;
      end
   end

endmodule : sseb_bank

// ---- core/sseb_defines.svh ----
// Constants of the status and event enable register bank.
`ifndef SSEB_DEFINES_SVH
`define SSEB_DEFINES_SVH

// Register selects.
`define SSEB_SEL_OPER_COND  3'h0
`define SSEB_SEL_OPER_EVT   3'h1
`define SSEB_SEL_OPER_MASK  3'h2
`define SSEB_SEL_QUES_EVT   3'h3
`define SSEB_SEL_QUES_MASK  3'h4
`define SSEB_SEL_INST_EVT   3'h5
`define SSEB_SEL_INST_MASK  3'h6
`define SSEB_SEL_MEAS_EVT   3'h7

// The measurement mask uses a fourth bit of select space.
`define SSEB_SEL_MEAS_MASK  4'h8

// Writable bit positions of each mask.
`define SSEB_OPER_USED      16'h0030
`define SSEB_QUES_USED      16'h5a13
`define SSEB_INST_USED      8'hea
`define SSEB_MEAS_USED      8'hea

// Reset values.
`define SSEB_RST_16         16'h0000
`define SSEB_RST_8          8'h00

// Largest value a mask write may carry.
`define SSEB_MAX_16         32'h0000ffff
`define SSEB_MAX_8          32'h000000ff

`endif

// ---- core/sseb_pkg.sv ----
// Types shared by the status and event enable register bank.
package sseb_pkg;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic [3:0]  sel;
      logic [31:0] value;
   } sseb_cmd_t;

   typedef struct packed {
      logic        valid;
      logic [15:0] data;
      logic        exec_error;
   } sseb_rsp_t;

   typedef enum logic [1:0] {
      SSEB_IDLE,
      SSEB_ANSWER
   } sseb_state_t;

endpackage : sseb_pkg

// ---- core/sseb_event_reg.sv ----
// One latching event register that clears on read, with its mask and summary.
`timescale 1ns/1ps
`include "sseb_defines.svh"

module sseb_event_reg #(
   parameter int WIDTH = 16
) (
   // Clock and reset
   input  wire logic             ref_clk,
   input  wire logic             rst_n,
   // Event sources and read clear
   input  wire logic [WIDTH-1:0] event_in,
   input  wire logic             read_clear,
   input  wire logic [WIDTH-1:0] mask,
   // State
   output logic      [WIDTH-1:0] value,
   output logic                  summary
);

   // Refuse at elaboration a width that the 16-bit answer path cannot carry.
   if (WIDTH < 1 || WIDTH > 16) begin : g_bad_width
      $error("sseb_event_reg width out of range");
   end

   logic [WIDTH-1:0] next_value;

   // An event in the read cycle is kept, so nothing raised while reading is lost.
   always_comb begin
      next_value = read_clear ? event_in : (value | event_in);
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         value <= '0;
      end else begin
         value <= next_value;
      end
   end

   assign summary = |(value & mask);

endmodule : sseb_event_reg

// ---- core/sseb_mask_reg.sv ----
// One enable mask with range clamping and unused bits forced to zero.
`timescale 1ns/1ps
`include "sseb_defines.svh"

module sseb_mask_reg #(
   parameter int              WIDTH = 16,
   parameter logic [15:0]     USED  = 16'hffff
) (
   // Clock and reset
   input  wire logic             ref_clk,
   input  wire logic             rst_n,
   // Write port
   input  wire logic             write,
   input  wire logic [31:0]      wr_value,
   // State
   output logic      [WIDTH-1:0] mask,
   output logic                  range_error
);

   // Only the two documented limits are known, so other widths are refused at elaboration.
   if (WIDTH != 8 && WIDTH != 16) begin : g_bad_width
      $error("sseb_mask_reg width must be 8 or 16");
   end

   localparam logic [31:0] MAX_VALUE = (WIDTH == 8) ? `SSEB_MAX_8 : `SSEB_MAX_16;

   logic [WIDTH-1:0] next_mask;
   logic [WIDTH-1:0] clamped;

   // The value is an unsigned count, so only the upper limit can be crossed.
   always_comb begin
      range_error = write && (wr_value > MAX_VALUE);
      clamped     = range_error ? MAX_VALUE[WIDTH-1:0] : wr_value[WIDTH-1:0];
      next_mask   = write ? (clamped & USED[WIDTH-1:0]) : mask;
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         mask <= '0;
      end else begin
         mask <= next_mask;
      end
   end

endmodule : sseb_mask_reg

// ---- dv/sseb_sva.sv ----
// Port-level checks of the status and event enable register bank.
`timescale 1ns/1ps

module sseb_sva (
   // Clock and reset
   input wire logic                ref_clk,
   input wire logic                rst_n,
   // Request and answer
   input wire sseb_pkg::sseb_cmd_t cmd,
   input wire sseb_pkg::sseb_rsp_t rsp,
   // Operation sources and summary
   input wire logic [15:0]         operation_condition,
   input wire logic [15:0]         operation_set,
   input wire logic                operation_summary
);
   wire logic rd = cmd.valid && !cmd.write;
   wire logic wr = cmd.valid && cmd.write;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////////////////////////
   property p_answer; cmd.valid |=> rsp.valid; endproperty
   a_answer: assert property (p_answer) else $error("request got no answer");
   property p_quiet; !cmd.valid |=> !rsp.valid && rsp.data == 16'h0 && !rsp.exec_error; endproperty
   a_quiet: assert property (p_quiet) else $error("answer without request");
   property p_cond; rd && cmd.sel == 4'h0 |=> rsp.data == $past(operation_condition); endproperty
   a_cond: assert property (p_cond) else $error("condition read wrong");
   property p_oper_used; rd && cmd.sel == 4'h2 |=> (rsp.data & 16'hffcf) == 16'h0; endproperty
   a_oper_used: assert property (p_oper_used) else $error("operation mask unused bit set");
   property p_ques_used; rd && cmd.sel == 4'h4 |=> (rsp.data & 16'ha5ec) == 16'h0; endproperty
   a_ques_used: assert property (p_ques_used) else $error("questionable mask unused bit set");
   property p_small_used; rd && (cmd.sel == 4'h6 || cmd.sel == 4'h8) |=> (rsp.data & 16'hff15) == 16'h0; endproperty
   a_small_used: assert property (p_small_used) else $error("8-bit mask unused bit set");
   property p_clamp; wr && cmd.sel == 4'h2 && cmd.value > 32'h0000ffff |=> rsp.exec_error; endproperty
   a_clamp: assert property (p_clamp) else $error("out-of-range write not flagged");
   property p_in_range; wr && cmd.value <= 32'h000000ff |=> !rsp.exec_error; endproperty
   a_in_range: assert property (p_in_range) else $error("in-range write flagged");
   property p_clear;
      (rd && cmd.sel == 4'h1 && operation_set == 16'h0) ##1 (!cmd.valid && operation_set == 16'h0)
      ##1 (rd && cmd.sel == 4'h1) |=> rsp.data == 16'h0;
   endproperty
   a_clear: assert property (p_clear) else $error("event not cleared by read");
   property p_latch;
      (operation_set == 16'hffff && !cmd.valid) ##1 !cmd.valid ##1 (rd && cmd.sel == 4'h1) |=> rsp.data == 16'hffff;
   endproperty
   a_latch: assert property (p_latch) else $error("event not latched");
   property p_sum_clear; rd && cmd.sel == 4'h1 && operation_set == 16'h0 |=> !operation_summary; endproperty
   a_sum_clear: assert property (p_sum_clear) else $error("summary after clear");
endmodule : sseb_sva

// ---- dv/sseb_host.sv ----
// Remote controller model issuing status queries and mask commands.
`timescale 1ns/1ps

module sseb_host (
   // Clock
   input  wire logic                ref_clk,
   // Request and answer
   output sseb_pkg::sseb_cmd_t      cmd,
   input  wire sseb_pkg::sseb_rsp_t rsp
);
   initial cmd = '0;
   // The gap lets a slow controller leave idle cycles before its request.
   task automatic xact(input int gap, input logic w, input logic [3:0] sel, input logic [31:0] val,
                       output logic [15:0] data, output logic err, output logic vld);
      repeat (gap) @(posedge ref_clk);
      @(posedge ref_clk);
      cmd <= '{1'b1, w, sel, val};
      @(posedge ref_clk);
      cmd <= '0;
      @(negedge ref_clk);
      vld  = rsp.valid;
      data = rsp.data;
      err  = rsp.exec_error;
   endtask : xact
endmodule : sseb_host

// ---- dv/tb_top.sv ----
// Self-checking testbench of the status and event enable register bank.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
   $display("unexpected %s expected %h seen %h", nm, e, g); end end

module tb_top;
   logic                ref_clk  = 1'b0;
   logic                rst_n    = 1'b0;
   logic [15:0]         cond     = 16'h0;
   logic [15:0]         oset     = 16'h0;
   logic [15:0]         qset     = 16'h0;
   logic [7:0]          iset     = 8'h0;
   logic [7:0]          mset     = 8'h0;
   logic [3:0]          sums;
   sseb_pkg::sseb_cmd_t cmd;
   sseb_pkg::sseb_rsp_t rsp;
   int                  n_fail   = 0;
   int                  n_checks = 0;
   logic [3:0]          esel [4] = '{4'h1, 4'h3, 4'h5, 4'h7};
   logic [3:0]          msel [4] = '{4'h2, 4'h4, 4'h6, 4'h8};
   logic [15:0]         full [4] = '{16'hffff, 16'hffff, 16'h00ff, 16'h00ff};
   logic [15:0]         used [4] = '{16'h0030, 16'h5a13, 16'h00ea, 16'h00ea};

   always #20 ref_clk = ~ref_clk;

   sseb_bank dut (.ref_clk(ref_clk), .rst_n(rst_n), .cmd(cmd), .rsp(rsp), .operation_condition(cond),
      .operation_set(oset), .questionable_set(qset), .instrument_error_set(iset), .measurement_set(mset),
      .operation_summary(sums[0]), .questionable_summary(sums[1]), .instrument_error_summary(sums[2]),
      .measurement_summary(sums[3]));
   sseb_host host (.ref_clk(ref_clk), .cmd(cmd), .rsp(rsp));
   ////////////////////////////////////////////////////////////
   task automatic acc(input int g, input logic w, input logic [3:0] s, input logic [31:0] v,
                      input logic [15:0] ed, input logic ee);
      logic [15:0] d;
      logic        e;
      logic        vl;
      host.xact(g, w, s, v, d, e, vl);
      `CHK("answer valid", 1'b1, vl)
      `CHK("answer data", ed, d)
      `CHK("exec error", ee, e)
   endtask : acc

   task automatic pulse(input int i, input logic [15:0] p);
      @(posedge ref_clk);
      oset <= (i == 0) ? p : 16'h0;
      qset <= (i == 1) ? p : 16'h0;
      iset <= (i == 2) ? p[7:0] : 8'h0;
      mset <= (i == 3) ? p[7:0] : 8'h0;
      @(posedge ref_clk);
      {oset, qset, iset, mset} <= 48'h0;
   endtask : pulse

   task automatic t_cond;
      acc(0, 1'b0, 4'h2, 32'h0, 16'h0, 1'b0);
      @(posedge ref_clk);
      cond <= 16'ha5c3;
      acc(3, 1'b0, 4'h0, 32'h0, 16'ha5c3, 1'b0);
      acc(0, 1'b0, 4'h0, 32'h0, 16'ha5c3, 1'b0);
   endtask : t_cond

   task automatic t_events;
      for (int i = 0; i < 4; i++) begin
         pulse(i, 16'h00a5);
         pulse(i, 16'hff5a);
         acc(0, 1'b0, esel[i], 32'h0, full[i], 1'b0);
         pulse(i, 16'hffff);
         acc(0, 1'b0, esel[i], 32'h0, full[i], 1'b0);
         acc(0, 1'b0, esel[i], 32'h0, 16'h0, 1'b0);
      end
   endtask : t_events

   task automatic t_masks;
      for (int i = 0; i < 4; i++) begin
         acc(0, 1'b1, msel[i], {16'h0, full[i]}, 16'h0, 1'b0);
         acc(0, 1'b0, msel[i], 32'h0, used[i], 1'b0);
         acc(0, 1'b1, msel[i], 32'h0, 16'h0, 1'b0);
         acc(0, 1'b0, msel[i], 32'h0, 16'h0, 1'b0);
         acc(0, 1'b1, msel[i], {16'h0, full[i]} + 32'h1, 16'h0, 1'b1);
         acc(0, 1'b0, msel[i], 32'h0, used[i], 1'b0);
      end
   endtask : t_masks

   task automatic t_summary;
      for (int i = 0; i < 4; i++) begin
         pulse(i, ~used[i]);
         @(negedge ref_clk);
         `CHK("masked summary", 1'b0, sums[i])
         pulse(i, used[i]);
         @(negedge ref_clk);
         `CHK("summary", 1'b1, sums[i])
         acc(0, 1'b0, esel[i], 32'h0, full[i], 1'b0);
         `CHK("cleared summary", 1'b0, sums[i])
      end
   endtask : t_summary

   // An event that arrives with the read must survive the clear; a mid-run reset must empty the operation mask, event register and summary.
   task automatic t_misc;
      acc(0, 1'b1, 4'h1, 32'h0000ffff, 16'h0, 1'b0);
      fork
         acc(0, 1'b0, 4'h1, 32'h0, 16'h0, 1'b0);
         begin
            @(posedge ref_clk);
            oset <= 16'h0008;
            @(posedge ref_clk);
            oset <= 16'h0000;
         end
      join
      acc(0, 1'b0, 4'h1, 32'h0, 16'h0008, 1'b0);
      acc(0, 1'b0, 4'h9, 32'h0, 16'h0, 1'b0);
      pulse(0, 16'h0030);
      @(negedge ref_clk);
      `CHK("summary before reset", 1'b1, sums[0])
      @(posedge ref_clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(negedge ref_clk);
      `CHK("summary after reset", 1'b0, sums[0])
      acc(0, 1'b0, 4'h2, 32'h0, 16'h0, 1'b0);
      acc(0, 1'b0, 4'h1, 32'h0, 16'h0, 1'b0);
   endtask : t_misc

   task automatic conclude;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : conclude

   initial begin
      repeat (16) @(posedge ref_clk);
      rst_n <= 1'b1;
      t_cond();
      t_events();
      t_masks();
      t_summary();
      t_misc();
      conclude();
   end

   // The tests need well under a thousand cycles; this leaves wide margin.
   initial begin
      repeat (4000) @(posedge ref_clk);
      n_fail++;
      conclude();
   end
endmodule : tb_top

bind sseb_bank sseb_sva chk (.ref_clk(ref_clk), .rst_n(rst_n), .cmd(cmd), .rsp(rsp),
   .operation_condition(operation_condition), .operation_set(operation_set), .operation_summary(operation_summary));
